// ---- src/hs_timer_pkg.sv ----
// shared constants, register map and carrier types of the high speed timer core
package hs_timer_pkg;

  // ****************************************
  // widths and fixed values
  // ****************************************
  localparam int          CNT_W        = 10;
  localparam int          DATA_W       = 8;
  localparam int          ADDR_W       = 4;
  localparam int          HI_W         = CNT_W - DATA_W;
  localparam int          PRESC_W      = 14;
  localparam int          CS_W         = 4;
  localparam int          NFLAG        = 5;
  localparam logic [9:0]  CNT_ZERO     = 10'h000;
  localparam logic [9:0]  CNT_MAX      = 10'h3ff;
  localparam logic [9:0]  TOP_RST      = 10'h0ff;
  localparam logic [9:0]  CNT_ONE      = 10'h001;
  localparam logic [3:0]  CS_STOP      = 4'h0;

  // ****************************************
  // register offsets on the cpu bus
  // ****************************************
  localparam logic [3:0]  OFS_CTRL_A   = 4'h0;
  localparam logic [3:0]  OFS_CTRL_B   = 4'h1;
  localparam logic [3:0]  OFS_CTRL_C   = 4'h2;
  localparam logic [3:0]  OFS_CTRL_D   = 4'h3;
  localparam logic [3:0]  OFS_COUNT    = 4'h4;
  localparam logic [3:0]  OFS_UPPER    = 4'h5;
  localparam logic [3:0]  OFS_CMP_A    = 4'h6;
  localparam logic [3:0]  OFS_CMP_B    = 4'h7;
  localparam logic [3:0]  OFS_TOP      = 4'h8;
  localparam logic [3:0]  OFS_CMP_D    = 4'h9;
  localparam logic [3:0]  OFS_FLAGS    = 4'ha;
  localparam logic [3:0]  OFS_MASKS    = 4'hb;
  localparam logic [3:0]  OFS_PLL      = 4'hc;

  // ****************************************
  // field positions
  // ****************************************
  localparam int          B_PWM_A      = 0;   // ctrl_reg_a
  localparam int          B_PWM_B      = 1;   // ctrl_reg_a
  localparam int          B_PWM_D      = 0;   // ctrl_reg_c
  localparam int          B_PSR        = 6;   // ctrl_reg_b, strobe
  localparam int          B_WGM        = 0;   // ctrl_reg_d
  localparam int          B_FLT_FLAG   = 6;   // ctrl_reg_d
  localparam int          B_FLT_MASK   = 7;   // ctrl_reg_d
  localparam int          B_OVF        = 0;   // flag and mask positions
  localparam int          B_MA         = 1;
  localparam int          B_MB         = 2;
  localparam int          B_MD         = 3;
  localparam int          B_FLT        = 4;   // irq vector only
  localparam int          B_HALF       = 7;   // pll_ctrl_status_reg
  localparam int          B_FCE        = 2;
  localparam int          B_PLLON      = 1;
  localparam int          B_LOCK       = 0;

  // ****************************************
  // carriers
  // ****************************************
  typedef struct packed {
    logic              wr;
    logic              rd;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } cpu_req_t;

  typedef struct packed {
    logic [CS_W-1:0]  cs;
    logic             fce;
    logic             half;
    logic             wgm;
    logic [2:0]       pwm;     // d, b, a
    logic [CNT_W-1:0] top;
    logic [CNT_W-1:0] cmp_a;
    logic [CNT_W-1:0] cmp_b;
    logic [CNT_W-1:0] cmp_d;
  } timer_cfg_t;

endpackage

// ---- src/hs_timer_core.sv ----
// counter core of the 10-bit high speed timer with its 8-bit register port
`timescale 1ns/1ps
`default_nettype none

module hs_timer_core
  import hs_timer_pkg::*;
(
  // clock and reset
  input  wire  logic              clk_i,
  input  wire  logic              rst_n_i,
  // cpu register port
  input  wire  cpu_req_t          cpu_req_i,
  output logic [DATA_W-1:0]       cpu_rdata_o,
  // fast peripheral clock tick and pll
  input  wire  logic              fast_tick_i,
  input  wire  logic              pll_locked_i,
  output logic                    pll_on_o,
  // fault and interrupt service
  input  wire  logic              fault_i,
  input  wire  logic [NFLAG-1:0]  irq_ack_i,
  output logic [NFLAG-1:0]        irq_o,
  // waveform side
  output logic                    wave_out_a_o,
  output logic                    wave_out_b_o,
  output logic                    wave_out_d_o,
  output logic                    top_o,
  output logic                    bottom_o,
  output logic                    max_o
);

  // ****************************************
  // cpu side registers
  // ****************************************
  logic [DATA_W-1:0] ctrl_reg_a_reg, ctrl_reg_a_next;
  logic [CS_W-1:0]   ctrl_reg_b_reg, ctrl_reg_b_next;
  logic [DATA_W-1:0] ctrl_reg_c_reg, ctrl_reg_c_next;
  logic [DATA_W-1:0] ctrl_reg_d_reg, ctrl_reg_d_next;
  logic [CNT_W-1:0]  cmp_a_reg, cmp_a_next;
  logic [CNT_W-1:0]  cmp_b_reg, cmp_b_next;
  logic [CNT_W-1:0]  top_reg, top_next;
  logic [CNT_W-1:0]  cmp_d_reg, cmp_d_next;
  logic [HI_W-1:0]   upper_reg, upper_next;
  logic [3:0]        mask_reg, mask_next;
  logic              half_reg, half_next;
  logic              fce_reg, fce_next;
  logic              pll_on_reg, pll_on_next;
  logic [DATA_W-1:0] rdata_reg, rdata_next;
  logic              psr_strobe;
  logic              cnt_wr;
  logic [CNT_W-1:0]  cnt_wr_val;
  logic [3:0]        flag_clr;
  logic              flt_clr;

  // ****************************************
  // timer side state
  // ****************************************
  timer_cfg_t        cfg_sync_reg, cfg_next;
  logic              cwr_sync_reg;
  logic [CNT_W-1:0]  cwv_sync_reg;
  logic              psr_sync_reg;
  logic [CNT_W-1:0]  cnt_reg, cnt_next;
  logic              down_reg, down_next;
  logic              block_reg, block_next;
  logic [3:0]        flag_reg, flag_next;
  logic              flt_reg, flt_next;
  logic [PRESC_W-1:0] presc_reg, presc_next;
  logic              half_tog_reg, half_tog_next;
  logic [CNT_W-1:0]  cnt_view_reg;
  logic [3:0]        flag_view_reg;
  logic [2:0]        wave_reg, wave_next;
  logic [NFLAG-1:0]  irq_reg, irq_next;
  logic              top_reg_o, bot_reg_o, max_reg_o;
  logic              src_tick, timer_tick;
  logic [PRESC_W-1:0] div_mask;

  // ****************************************
  // cpu register file
  // ****************************************

  // decode of reads and writes; reads answer one cycle later on cpu_rdata_o
  always_comb begin
    ctrl_reg_a_next = ctrl_reg_a_reg;
    ctrl_reg_b_next = ctrl_reg_b_reg;
    ctrl_reg_c_next = ctrl_reg_c_reg;
    ctrl_reg_d_next = ctrl_reg_d_reg;
    cmp_a_next      = cmp_a_reg;
    cmp_b_next      = cmp_b_reg;
    top_next        = top_reg;
    cmp_d_next      = cmp_d_reg;
    upper_next      = upper_reg;
    mask_next       = mask_reg;
    half_next       = half_reg;
    fce_next        = fce_reg;
    pll_on_next     = pll_on_reg;
    rdata_next      = rdata_reg;
    psr_strobe      = 1'b0;
    cnt_wr          = 1'b0;
    cnt_wr_val      = {upper_reg, cpu_req_i.wdata};
    flag_clr        = 4'h0;
    flt_clr         = 1'b0;
    if (cpu_req_i.wr) begin
      case (cpu_req_i.addr)
        OFS_CTRL_A: ctrl_reg_a_next = cpu_req_i.wdata;
        OFS_CTRL_B: begin
          ctrl_reg_b_next = cpu_req_i.wdata[CS_W-1:0];
          psr_strobe      = cpu_req_i.wdata[B_PSR];
        end
        OFS_CTRL_C: ctrl_reg_c_next = cpu_req_i.wdata;
        OFS_CTRL_D: begin
          // fault flag is not stored here; a one written to it clears it
          ctrl_reg_d_next             = cpu_req_i.wdata;
          ctrl_reg_d_next[B_FLT_FLAG] = 1'b0;
          flt_clr                     = cpu_req_i.wdata[B_FLT_FLAG];
        end
        OFS_COUNT:  cnt_wr = 1'b1;
        OFS_UPPER:  upper_next = cpu_req_i.wdata[HI_W-1:0];
        OFS_CMP_A:  cmp_a_next = {upper_reg, cpu_req_i.wdata};
        OFS_CMP_B:  cmp_b_next = {upper_reg, cpu_req_i.wdata};
        OFS_TOP:    top_next   = {upper_reg, cpu_req_i.wdata};
        OFS_CMP_D:  cmp_d_next = {upper_reg, cpu_req_i.wdata};
        OFS_FLAGS:  flag_clr   = cpu_req_i.wdata[3:0];
        OFS_MASKS:  mask_next  = cpu_req_i.wdata[3:0];
        OFS_PLL: begin
          half_next   = cpu_req_i.wdata[B_HALF];
          pll_on_next = cpu_req_i.wdata[B_PLLON];
          // fast clock can only be switched on while the pll is on or in the write that turns it on
          fce_next    = cpu_req_i.wdata[B_FCE] & (pll_on_reg | cpu_req_i.wdata[B_PLLON]);
        end
        default: ;
      endcase
    end else if (cpu_req_i.rd) begin
      rdata_next = '0;
      case (cpu_req_i.addr)
        OFS_CTRL_A: rdata_next = ctrl_reg_a_reg;
        OFS_CTRL_B: rdata_next = {4'h0, ctrl_reg_b_reg};  // prescaler reset reads zero
        OFS_CTRL_C: rdata_next = ctrl_reg_c_reg;
        OFS_CTRL_D: begin
          rdata_next             = ctrl_reg_d_reg;
          rdata_next[B_FLT_FLAG] = flt_reg;
        end
        OFS_COUNT: begin
          rdata_next = cnt_view_reg[DATA_W-1:0];
          upper_next = cnt_view_reg[CNT_W-1:DATA_W];
        end
        OFS_UPPER:  rdata_next = {6'h00, upper_reg};
        OFS_CMP_A: begin
          rdata_next = cmp_a_reg[DATA_W-1:0];
          upper_next = cmp_a_reg[CNT_W-1:DATA_W];
        end
        OFS_CMP_B: begin
          rdata_next = cmp_b_reg[DATA_W-1:0];
          upper_next = cmp_b_reg[CNT_W-1:DATA_W];
        end
        OFS_TOP: begin
          rdata_next = top_reg[DATA_W-1:0];
          upper_next = top_reg[CNT_W-1:DATA_W];
        end
        OFS_CMP_D: begin
          rdata_next = cmp_d_reg[DATA_W-1:0];
          upper_next = cmp_d_reg[CNT_W-1:DATA_W];
        end
        OFS_FLAGS:  rdata_next = {4'h0, flag_view_reg};
        OFS_MASKS:  rdata_next = {4'h0, mask_reg};
        OFS_PLL: begin
          rdata_next[B_HALF]  = half_reg;
          rdata_next[B_FCE]   = fce_reg;
          rdata_next[B_PLLON] = pll_on_reg;
          rdata_next[B_LOCK]  = pll_locked_i;
        end
        default: rdata_next = '0;
      endcase
    end
  end

  // cpu registers; top limit starts at the 8-bit maximum
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ctrl_reg_a_reg <= '0;
      ctrl_reg_b_reg <= CS_STOP;
      ctrl_reg_c_reg <= '0;
      ctrl_reg_d_reg <= '0;
      cmp_a_reg      <= CNT_ZERO;
      cmp_b_reg      <= CNT_ZERO;
      top_reg        <= TOP_RST;
      cmp_d_reg      <= CNT_ZERO;
      upper_reg      <= '0;
      mask_reg       <= '0;
      half_reg       <= 1'b0;
      fce_reg        <= 1'b0;
      pll_on_reg     <= 1'b0;
      rdata_reg      <= '0;
    end else begin
      ctrl_reg_a_reg <= ctrl_reg_a_next;
      ctrl_reg_b_reg <= ctrl_reg_b_next;
      ctrl_reg_c_reg <= ctrl_reg_c_next;
      ctrl_reg_d_reg <= ctrl_reg_d_next;
      cmp_a_reg      <= cmp_a_next;
      cmp_b_reg      <= cmp_b_next;
      top_reg        <= top_next;
      cmp_d_reg      <= cmp_d_next;
      upper_reg      <= upper_next;
      mask_reg       <= mask_next;
      half_reg       <= half_next;
      fce_reg        <= fce_next;
      pll_on_reg     <= pll_on_next;
      rdata_reg      <= rdata_next;
    end
  end

  // ****************************************
  // input sync stage toward the counter
  // ****************************************

  // settings reach the counter one cycle after the cpu writes them
  always_comb begin
    cfg_next.cs    = ctrl_reg_b_reg;
    cfg_next.fce   = fce_reg;
    cfg_next.half  = half_reg;
    cfg_next.wgm   = ctrl_reg_d_reg[B_WGM];
    cfg_next.pwm   = {ctrl_reg_c_reg[B_PWM_D], ctrl_reg_a_reg[B_PWM_B], ctrl_reg_a_reg[B_PWM_A]};
    cfg_next.top   = top_reg;
    cfg_next.cmp_a = cmp_a_reg;
    cfg_next.cmp_b = cmp_b_reg;
    cfg_next.cmp_d = cmp_d_reg;
  end

  // sync stage registers
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cfg_sync_reg <= '{cs: CS_STOP, top: TOP_RST, default: '0};
      cwr_sync_reg <= 1'b0;
      cwv_sync_reg <= CNT_ZERO;
      psr_sync_reg <= 1'b0;
    end else begin
      cfg_sync_reg <= cfg_next;
      cwr_sync_reg <= cnt_wr;
      cwv_sync_reg <= cnt_wr_val;
      psr_sync_reg <= psr_strobe;
    end
  end

  // ****************************************
  // prescaler and counter
  // ****************************************

  // tick source, prescaler and count sequence
  always_comb begin
    // fast ticks arrive as one-cycle pulses; half speed passes every second one
    src_tick      = cfg_sync_reg.fce ? (fast_tick_i & (~cfg_sync_reg.half | half_tog_reg))
                                     : 1'b1;
    half_tog_next = (cfg_sync_reg.fce & fast_tick_i) ? ~half_tog_reg : half_tog_reg;
    div_mask      = (cfg_sync_reg.cs == CS_STOP) ? '0
                  : PRESC_W'((15'h0001 << (cfg_sync_reg.cs - CS_W'(1))) - 15'h0001);
    timer_tick    = (cfg_sync_reg.cs != CS_STOP) & src_tick
                  & ((presc_reg & div_mask) == div_mask);
    presc_next    = psr_sync_reg ? '0 : (src_tick ? presc_reg + PRESC_W'(1) : presc_reg);
    cnt_next      = cnt_reg;
    down_next     = down_reg;
    block_next    = block_reg;
    flag_next     = flag_reg & ~flag_clr & ~irq_ack_i[3:0];
    flt_next      = flt_reg & ~flt_clr & ~irq_ack_i[B_FLT];
    if (cwr_sync_reg) begin
      // a cpu write wins and masks the match on the next tick
      cnt_next   = cwv_sync_reg;
      block_next = 1'b1;
    end else if (timer_tick) begin
      block_next = 1'b0;
      if (cfg_sync_reg.wgm && (cfg_sync_reg.pwm != 3'h0)) begin
        // up to top and back down, overflow at bottom
        if (!down_reg && cnt_reg == cfg_sync_reg.top) begin
          down_next = 1'b1;
          cnt_next  = cnt_reg - CNT_ONE;
        end else if (down_reg && cnt_reg == CNT_ZERO) begin
          down_next         = 1'b0;
          cnt_next          = CNT_ONE;
          flag_next[B_OVF]  = 1'b1;
        end else begin
          cnt_next = down_reg ? cnt_reg - CNT_ONE : cnt_reg + CNT_ONE;
        end
      end else begin
        down_next = 1'b0;
        if (cnt_reg == cfg_sync_reg.top) begin
          cnt_next         = CNT_ZERO;
          flag_next[B_OVF] = 1'b1;
        end else begin
          cnt_next = cnt_reg + CNT_ONE;
        end
      end
    end
    if (timer_tick && !block_reg && !cwr_sync_reg) begin
      if (cnt_reg == cfg_sync_reg.cmp_a) flag_next[B_MA] = 1'b1;
      if (cnt_reg == cfg_sync_reg.cmp_b) flag_next[B_MB] = 1'b1;
      if (cnt_reg == cfg_sync_reg.cmp_d) flag_next[B_MD] = 1'b1;
    end
    if (fault_i) flt_next = 1'b1;  // set wins over clear
  end

  // counter state; counter cleared at reset
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cnt_reg      <= CNT_ZERO;
      down_reg     <= 1'b0;
      block_reg    <= 1'b0;
      flag_reg     <= '0;
      flt_reg      <= 1'b0;
      presc_reg    <= '0;
      half_tog_reg <= 1'b0;
    end else begin
      cnt_reg      <= cnt_next;
      down_reg     <= down_next;
      block_reg    <= block_next;
      flag_reg     <= flag_next;
      flt_reg      <= flt_next;
      presc_reg    <= presc_next;
      half_tog_reg <= half_tog_next;
    end
  end

  // ****************************************
  // output stage and readback views
  // ****************************************

  // pwm channels follow count below compare, others toggle on match
  always_comb begin
    wave_next = wave_reg;
    if (timer_tick && !block_reg && !cwr_sync_reg) begin
      wave_next[0] = cfg_sync_reg.pwm[0] ? (cnt_reg < cfg_sync_reg.cmp_a)
                   : wave_reg[0] ^ (cnt_reg == cfg_sync_reg.cmp_a);
      wave_next[1] = cfg_sync_reg.pwm[1] ? (cnt_reg < cfg_sync_reg.cmp_b)
                   : wave_reg[1] ^ (cnt_reg == cfg_sync_reg.cmp_b);
      wave_next[2] = cfg_sync_reg.pwm[2] ? (cnt_reg < cfg_sync_reg.cmp_d)
                   : wave_reg[2] ^ (cnt_reg == cfg_sync_reg.cmp_d);
    end
    irq_next         = '0;
    irq_next[3:0]    = flag_reg & mask_reg;
    irq_next[B_FLT]  = flt_reg & ctrl_reg_d_reg[B_FLT_MASK];
  end

  // registered outputs and delayed readback copies
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      wave_reg      <= '0;
      irq_reg       <= '0;
      top_reg_o     <= 1'b0;
      bot_reg_o     <= 1'b0;
      max_reg_o     <= 1'b0;
      cnt_view_reg  <= CNT_ZERO;
      flag_view_reg <= '0;
    end else begin
      wave_reg      <= wave_next;
      irq_reg       <= irq_next;
      top_reg_o     <= (cnt_reg == cfg_sync_reg.top);
      bot_reg_o     <= (cnt_reg == CNT_ZERO);
      max_reg_o     <= (cnt_reg == CNT_MAX);
      cnt_view_reg  <= cnt_reg;
      flag_view_reg <= flag_reg;
    end
  end

  // port drive
  assign cpu_rdata_o  = rdata_reg;
  assign pll_on_o     = pll_on_reg;
  assign irq_o        = irq_reg;
  assign wave_out_a_o = wave_reg[0];
  assign wave_out_b_o = wave_reg[1];
  assign wave_out_d_o = wave_reg[2];
  assign top_o        = top_reg_o;
  assign bottom_o     = bot_reg_o;
  assign max_o        = max_reg_o;

endmodule

`default_nettype wire

// ---- verif/hs_timer_asserts.sv ----
// port assertions of the high speed timer core
`timescale 1ns/1ps
`default_nettype none
module hs_timer_asserts
  import hs_timer_pkg::*;
(
  // watched ports
  input wire logic              clk_i,
  input wire logic              rst_n_i,
  input wire cpu_req_t          cpu_req_i,
  input wire logic [DATA_W-1:0] cpu_rdata_o,
  input wire logic              pll_locked_i,
  input wire logic              pll_on_o,
  input wire logic [NFLAG-1:0]  irq_o,
  input wire logic              bottom_o,
  input wire logic              max_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);
  logic             rd;
  logic             wr;
  logic [NFLAG-1:0] msk_reg;
  logic [NFLAG-1:0] msk_next;
  assign rd = cpu_req_i.rd & ~cpu_req_i.wr;
  assign wr = cpu_req_i.wr;
  // shadow of all mask bits, the fault mask lives apart in ctrl_reg_d
  always_comb begin
    msk_next = msk_reg;
    if (wr && cpu_req_i.addr == OFS_MASKS) msk_next[3:0] = cpu_req_i.wdata[3:0];
    if (wr && cpu_req_i.addr == OFS_CTRL_D) msk_next[B_FLT] = cpu_req_i.wdata[B_FLT_MASK];
  end
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) msk_reg <= '0;
    else msk_reg <= msk_next;
  end
  // ******
  // checks
  // ******
  rdata_hold_a: assert property (!rd |=> $stable(cpu_rdata_o)) else $error("read data moved");
  unmapped_zero_a: assert property (rd && cpu_req_i.addr > OFS_PLL |=> cpu_rdata_o == 8'h00)
    else $error("unmapped read not zero");
  readback_a: assert property ((wr && cpu_req_i.addr inside {[OFS_CMP_A:OFS_CMP_D]}) ##1
    (rd && cpu_req_i.addr == $past(cpu_req_i.addr)) |=> cpu_rdata_o == $past(cpu_req_i.wdata, 2))
    else $error("compare readback wrong");
  pll_follow_a: assert property (wr && cpu_req_i.addr == OFS_PLL |=> pll_on_o == $past(cpu_req_i.wdata[B_PLLON]))
    else $error("pll enable not taken");
  pll_hold_a: assert property (!(wr && cpu_req_i.addr == OFS_PLL) |=> $stable(pll_on_o))
    else $error("pll enable moved");
  lock_view_a: assert property (rd && cpu_req_i.addr == OFS_PLL |=>
    cpu_rdata_o[B_LOCK] == $past(pll_locked_i) && cpu_rdata_o[6:3] == 4'h0) else $error("lock view wrong");
  strobe_zero_a: assert property (rd && cpu_req_i.addr == OFS_CTRL_B |=> !cpu_rdata_o[B_PSR])
    else $error("prescaler strobe read back");
  irq_mask_a: assert property ((irq_o & ~$past(msk_reg)) == '0) else $error("masked irq seen");
  ends_apart_a: assert property (max_o |-> !bottom_o) else $error("max and bottom together");
endmodule
bind hs_timer_core hs_timer_asserts hs_timer_asserts_i (.clk_i(clk_i), .rst_n_i(rst_n_i), .cpu_req_i(cpu_req_i),
  .cpu_rdata_o(cpu_rdata_o), .pll_locked_i(pll_locked_i), .pll_on_o(pll_on_o), .irq_o(irq_o),
  .bottom_o(bottom_o), .max_o(max_o));
`default_nettype wire

// ---- verif/pll_model.sv ----
// pll and fast peripheral clock tick model
`timescale 1ns/1ps
`default_nettype none
module pll_model #(
  parameter int LOCK_DLY = 20,
  parameter int FAST_DIV = 3
) (
  // clock and pll control
  input  wire logic clk_i,
  input  wire logic pll_on_i,
  // lock and fast ticks
  output var  logic locked_o,
  output var  logic tick_o
);
  int cnt = 0;
  int ph = 0;
  initial locked_o = 1'b0;
  initial tick_o = 1'b0;
  // lock only after settling, lost at once when switched off
  always @(posedge clk_i) begin
    cnt <= pll_on_i ? cnt + 1 : 0;
    locked_o <= pll_on_i && cnt >= LOCK_DLY;
    // ticks stay a few system cycles apart so the sync stage never drops one
    ph <= (ph == FAST_DIV - 1) ? 0 : ph + 1;
    tick_o <= locked_o && ph == 0;
  end
endmodule
`default_nettype wire

// ---- verif/tb_hs_timer_core.sv ----
// self-checking bench of the high speed timer core
`timescale 1ns/1ps
`default_nettype none
module tb_hs_timer_core;
  import hs_timer_pkg::*;
  logic clk_i = 1'b0;
  logic rst_n_i = 1'b0;
  cpu_req_t cpu_req_i = '0;
  logic [7:0] cpu_rdata_o, rv;
  logic fast_tick_i, pll_locked_i, pll_on_o, fault_i = 1'b0;
  logic [4:0] irq_ack_i = '0;
  logic [4:0] irq_o;
  logic wave_out_a_o, wave_out_b_o, wave_out_d_o, top_o, bottom_o, max_o;
  int errors = 0;
  int check_count = 0;
  always #5 clk_i = ~clk_i;
  hs_timer_core hs_timer_core_i (.clk_i(clk_i), .rst_n_i(rst_n_i), .cpu_req_i(cpu_req_i), .cpu_rdata_o(cpu_rdata_o),
    .fast_tick_i(fast_tick_i), .pll_locked_i(pll_locked_i), .pll_on_o(pll_on_o), .fault_i(fault_i),
    .irq_ack_i(irq_ack_i), .irq_o(irq_o), .wave_out_a_o(wave_out_a_o), .wave_out_b_o(wave_out_b_o),
    .wave_out_d_o(wave_out_d_o), .top_o(top_o), .bottom_o(bottom_o), .max_o(max_o));
  pll_model pll_model_i (.clk_i(clk_i), .pll_on_i(pll_on_o), .locked_o(pll_locked_i), .tick_o(fast_tick_i));
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    check_count++;
    if (got !== exp) begin
      errors++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  // one access per call, the bus idles a cycle so slow views settle
  task automatic acc(input logic w, input logic [3:0] a, input logic [7:0] d);
    @(negedge clk_i) cpu_req_i = '{w, ~w, a, d};
    @(negedge clk_i) cpu_req_i = '0;
    rv = cpu_rdata_o;
  endtask
  task automatic rd(input logic [3:0] a, input logic [7:0] e);
    acc(1'b0, a, 8'h00);
    chk(rv, e);
  endtask
  // write then read in the very next cycle
  task automatic wrrd(input logic [3:0] a, input logic [7:0] d);
    @(negedge clk_i) cpu_req_i = '{1'b1, 1'b0, a, d};
    rd(a, d);
  endtask
  // period in cycles between rises of the bottom indication
  task automatic per(input int e);
    realtime t;
    @(posedge bottom_o) t = $realtime;
    @(posedge bottom_o) chk(8'(int'(($realtime - t) / 10)), 8'(e));
  endtask
  task automatic results;
    $display("checks %0d errors %0d", check_count, errors);
    if (errors == 0 && check_count > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  // ******
  // tests
  // ******
  initial begin
    repeat (2) @(negedge clk_i);
    rst_n_i = 1'b1;
    rd(OFS_TOP, 8'hff);
    rd(OFS_UPPER, 8'h00);
    rd(OFS_COUNT, 8'h00);
    rd(OFS_CTRL_B, 8'h00);
    rd(4'hd, 8'h00);
    for (int i = 0; i < 4; i++) begin
      acc(1'b1, OFS_UPPER, 8'(i));
      wrrd(4'(OFS_CMP_A + i), 8'h30 + 8'(i));
      acc(1'b1, OFS_UPPER, 8'h00);
      rd(4'(OFS_CMP_A + i), 8'h30 + 8'(i));
      rd(OFS_UPPER, 8'(i));
    end
    // stopped counter still takes a full 10-bit write
    acc(1'b1, OFS_UPPER, 8'h03);
    acc(1'b1, OFS_COUNT, 8'hff);
    repeat (3) @(negedge clk_i);
    chk(8'(max_o), 8'h01);
    rd(OFS_COUNT, 8'hff);
    rd(OFS_UPPER, 8'h03);
    acc(1'b1, OFS_UPPER, 8'h00);
    acc(1'b1, OFS_COUNT, 8'h00);
    acc(1'b1, OFS_TOP, 8'h0f);
    acc(1'b1, OFS_CMP_A, 8'h03);
    acc(1'b1, OFS_CMP_B, 8'h05);
    acc(1'b1, OFS_CMP_D, 8'h07);
    acc(1'b1, OFS_FLAGS, 8'h0f);
    acc(1'b1, OFS_CTRL_B, 8'h01);
    per(16);
    acc(1'b1, OFS_CTRL_B, 8'h03);
    per(64);
    acc(1'b1, OFS_CTRL_B, 8'h00);
    rd(OFS_FLAGS, 8'h0f);
    acc(1'b1, OFS_MASKS, 8'h01);
    repeat (2) @(negedge clk_i);
    chk(8'(irq_o), 8'h01);
    irq_ack_i = 5'h01;
    @(negedge clk_i) irq_ack_i = '0;
    repeat (2) @(negedge clk_i);
    chk(8'(irq_o), 8'h00);
    rd(OFS_FLAGS, 8'h0e);
    acc(1'b1, OFS_FLAGS, 8'h0e);
    rd(OFS_FLAGS, 8'h00);
    // up and down counting with pwm a enabled
    acc(1'b1, OFS_CTRL_D, 8'h01);
    acc(1'b1, OFS_CTRL_A, 8'h01);
    acc(1'b1, OFS_CTRL_B, 8'h01);
    per(30);
    // from top down to bottom: 15 ticks, one match each for b and d on the way
    @(posedge top_o) @(negedge clk_i) rv = {6'h00, wave_out_d_o, wave_out_b_o};
    repeat (15) @(negedge clk_i);
    chk(8'(bottom_o), 8'h01);
    chk(8'(wave_out_a_o), 8'h01);
    chk({6'h00, wave_out_d_o, wave_out_b_o}, rv ^ 8'h03);
    acc(1'b1, OFS_CTRL_B, 8'h00);
    acc(1'b1, OFS_CTRL_A, 8'h00);
    acc(1'b1, OFS_CTRL_D, 8'h00);
    // pll start-up then fast clock, full and half speed
    acc(1'b1, OFS_PLL, 8'h02);
    rv = 8'h00;
    while (!rv[B_LOCK]) acc(1'b0, OFS_PLL, 8'h00);
    acc(1'b1, OFS_PLL, 8'h06);
    acc(1'b1, OFS_CTRL_B, 8'h01);
    per(48);
    acc(1'b1, OFS_PLL, 8'h86);
    per(96);
    acc(1'b1, OFS_CTRL_B, 8'h00);
    // counting set overflow again; clear it so only the fault irq remains
    acc(1'b1, OFS_FLAGS, 8'h0f);
    fault_i = 1'b1;
    @(negedge clk_i) fault_i = 1'b0;
    rd(OFS_CTRL_D, 8'h40);
    acc(1'b1, OFS_CTRL_D, 8'h80);
    repeat (2) @(negedge clk_i);
    chk(8'(irq_o), 8'h10);
    acc(1'b1, OFS_CTRL_D, 8'h40);
    rd(OFS_CTRL_D, 8'h00);
    // reset in mid-run restores the top limit
    rst_n_i = 1'b0;
    repeat (2) @(negedge clk_i);
    rst_n_i = 1'b1;
    rd(OFS_TOP, 8'hff);
    results();
  end
  // a hang ends the run as a failure
  initial begin
    #100000;
    errors++;
    results();
  end
endmodule
`default_nettype wire
